// ==== rtl/tccu_pkg.sv ====
package tccu_pkg;
   // Mode field encodings of the match control register.
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SWI = 4'ha;
   localparam logic [3:0] MODE_CMP_SET_TRIG = 4'hb;
   localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
   // Reset values, timer maximum and capture prescale limits.
   localparam logic [15:0] TIMER_RESET = 16'h0000;
   localparam logic [15:0] MATCH_RESET = 16'h0000;
   localparam logic [15:0] TIMER_MAX = 16'hffff;
   localparam logic [3:0] PRESCALE_RESET = 4'h0;
   localparam logic [3:0] PRESCALE_16 = 4'hf;
   localparam logic [3:0] PRESCALE_4 = 4'h3;
endpackage : tccu_pkg

// ==== rtl/tccu_timer_capture_compare_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module tccu_timer_capture_compare_unit
   import tccu_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic timerTick,
   input wire logic timerHighWrite,
   input wire logic timerLowWrite,
   input wire logic [7:0] timerWriteData,
   input wire logic matchHighWrite,
   input wire logic matchLowWrite,
   input wire logic [7:0] matchWriteData,
   input wire logic controlWrite,
   input wire logic [3:0] controlWriteData,
   input wire logic captureIn,
   input wire logic comparatorIn,
   input wire logic adcEnable,
   input wire logic matchFlagClear,
   input wire logic overflowFlagClear,
   output logic [15:0] timerPair,
   output logic [15:0] matchValuePair,
   output logic [3:0] matchModeField,
   output logic matchOutputPin,
   output logic pinDriven,
   output logic matchFlag,
   output logic timerOverflowFlag,
   output logic specialEventTrigger,
   output logic conversionGo,
   output logic comparatorSynced
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [15:0] timer_reg, timer_next;
   logic [15:0] match_reg, match_next;
   logic [3:0] mode_reg;
   logic outLatch_reg, outLatch_next;
   logic matchFlag_reg, ovfFlag_reg;
   logic trig_reg, go_reg, pinEn_reg;
   logic [3:0] capCount_reg;
   logic capMeta_reg, capSync_reg, capPrev_reg;
   logic cmpMeta_reg, cmpSync_reg, cmpTimed_reg;

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   // Mode class decode.
   wire isCapture = (mode_reg[3:2] == 2'b01);
   wire isCompare = mode_reg[3] || (mode_reg == MODE_CMP_TOGGLE);
   wire isTrig = (mode_reg == MODE_CMP_SET_TRIG);
   wire isSwi = (mode_reg == MODE_CMP_SWI);
   wire pinMode = isCompare && !isTrig && !isSwi;
   // Equality against the timer pair.
   wire equal = (match_reg == timer_reg);
   // Only a fresh match counts, so a held match fires once, and again after each timer write.
   logic equalPrev_reg;
   wire matchEvt = isCompare && equal && !equalPrev_reg;
   // Capture edge detection on the synchronised pin.
   wire capRise = capSync_reg && !capPrev_reg;
   wire capFall = !capSync_reg && capPrev_reg;
   wire capEdge = (mode_reg == MODE_CAP_FALL) ? capFall : capRise;
   wire [3:0] capDiv = (mode_reg == MODE_CAP_RISE16) ? PRESCALE_16 :
                       (mode_reg == MODE_CAP_RISE4) ? PRESCALE_4 :
                       PRESCALE_RESET;
   wire capEvt = isCapture && capEdge && (capCount_reg == capDiv);
   // Timer reset happens on the first tick while the match still holds;
   // a match that is gone by then drops the reset, even at one tick a cycle.
   wire trigReset = timerTick && isTrig && equal;
   wire wrap = timerTick && !trigReset && (timer_reg == TIMER_MAX);
   wire timerWr = timerHighWrite || timerLowWrite;

   // Next value of the timer; a write has top priority.
   always_comb begin
      timer_next = timer_reg;
      if (trigReset) begin
         timer_next = TIMER_RESET;
      end else if (timerTick) begin
         timer_next = timer_reg + 16'h0001;
      end
      if (timerHighWrite) begin
         timer_next[15:8] = timerWriteData;
      end
      if (timerLowWrite) begin
         timer_next[7:0] = timerWriteData;
      end
   end

   // Next value of the match pair: capture or software write.
   always_comb begin
      match_next = match_reg;
      if (capEvt) begin
         match_next = timer_reg;
      end
      if (matchHighWrite) begin
         match_next[15:8] = matchWriteData;
      end
      if (matchLowWrite) begin
         match_next[7:0] = matchWriteData;
      end
   end

   // Compare output latch actions.
   always_comb begin
      outLatch_next = outLatch_reg;
      if (matchEvt && pinMode) begin
         case (mode_reg)
            MODE_CMP_TOGGLE: outLatch_next = !outLatch_reg;
            MODE_CMP_SET: outLatch_next = 1'b1;
            MODE_CMP_CLR: outLatch_next = 1'b0;
            default: outLatch_next = outLatch_reg;
         endcase
      end
      if (controlWrite) begin
         if (controlWriteData == MODE_OFF) begin
            outLatch_next = 1'b0;
         end else if (controlWriteData == MODE_CMP_CLR) begin
            outLatch_next = 1'b1;
         end else if (controlWriteData == MODE_CMP_SET) begin
            outLatch_next = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Timer, match pair and mode.
   always_ff @(posedge mclk) begin
      if (reset) begin
         timer_reg <= TIMER_RESET;
         match_reg <= MATCH_RESET;
         mode_reg <= MODE_OFF;
         outLatch_reg <= 1'b0;
      end else begin
         timer_reg <= timer_next;
         match_reg <= match_next;
         mode_reg <= controlWrite ? controlWriteData : mode_reg;
         outLatch_reg <= outLatch_next;
      end
   end

   // Flags; a setting event wins over a clear.
   always_ff @(posedge mclk) begin
      if (reset) begin
         matchFlag_reg <= 1'b0;
         ovfFlag_reg <= 1'b0;
      end else begin
         matchFlag_reg <= (matchEvt || capEvt) ||
                          (matchFlag_reg && !matchFlagClear);
         ovfFlag_reg <= (wrap && !timerWr) ||
                        (ovfFlag_reg && !overflowFlagClear);
      end
   end

   // Trigger pulse, match history and conversion start.
   always_ff @(posedge mclk) begin
      if (reset) begin
         trig_reg <= 1'b0;
         go_reg <= 1'b0;
         equalPrev_reg <= 1'b0;
         pinEn_reg <= 1'b0;
      end else begin
         trig_reg <= matchEvt && isTrig;
         go_reg <= matchEvt && isTrig && adcEnable;
         equalPrev_reg <= equal && !timerWr;
         pinEn_reg <= pinMode;
      end
   end

   // Capture pin synchroniser and prescale counter.
   always_ff @(posedge mclk) begin
      if (reset) begin
         capMeta_reg <= 1'b0;
         capSync_reg <= 1'b0;
         capPrev_reg <= 1'b0;
         capCount_reg <= PRESCALE_RESET;
      end else begin
         capMeta_reg <= captureIn;
         capSync_reg <= capMeta_reg;
         capPrev_reg <= capSync_reg;
         if (!isCapture || controlWrite) begin
            capCount_reg <= PRESCALE_RESET;
         end else if (capEdge) begin
            capCount_reg <= (capCount_reg == capDiv) ? PRESCALE_RESET :
                            capCount_reg + 4'h1;
         end
      end
   end

   // Comparator output synchronised, then retimed on timer ticks.
   always_ff @(posedge mclk) begin
      if (reset) begin
         cmpMeta_reg <= 1'b0;
         cmpSync_reg <= 1'b0;
         cmpTimed_reg <= 1'b0;
      end else begin
         cmpMeta_reg <= comparatorIn;
         cmpSync_reg <= cmpMeta_reg;
         if (timerTick) begin
            cmpTimed_reg <= cmpSync_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign timerPair = timer_reg;
   assign matchValuePair = match_reg;
   assign matchModeField = mode_reg;
   assign matchOutputPin = outLatch_reg;
   assign pinDriven = pinEn_reg;
   assign matchFlag = matchFlag_reg;
   assign timerOverflowFlag = ovfFlag_reg;
   assign specialEventTrigger = trig_reg;
   assign conversionGo = go_reg;
   assign comparatorSynced = cmpTimed_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_trig_reset_timer: assert property (@(posedge mclk)
      disable iff (reset)
      (trigReset && !timerWr) |=> (timer_reg == TIMER_RESET))
      else $error("Trigger reset did not clear the timer.");
   a_write_wins_reset: assert property (@(posedge mclk)
      disable iff (reset)
      (trigReset && timerLowWrite)
      |=> (timer_reg[7:0] == $past(timerWriteData)))
      else $error("Timer write lost to trigger reset.");
   a_no_ovf_on_trig: assert property (@(posedge mclk)
      disable iff (reset)
      (trigReset && !ovfFlag_reg) |=> !ovfFlag_reg)
      else $error("Trigger reset set the overflow flag.");
   a_wrap_sets_ovf: assert property (@(posedge mclk)
      disable iff (reset)
      (wrap && !timerWr) |=> (ovfFlag_reg && timer_reg == TIMER_RESET))
      else $error("Wrap did not set overflow.");
   a_match_flag_set: assert property (@(posedge mclk)
      disable iff (reset)
      matchEvt |=> matchFlag_reg)
      else $error("Match did not raise the flag.");
   a_capture_copies: assert property (@(posedge mclk)
      disable iff (reset)
      (capEvt && !matchHighWrite && !matchLowWrite)
      |=> (match_reg == $past(timer_reg)))
      else $error("Capture did not copy the timer.");
   a_trig_pin_free: assert property (@(posedge mclk)
      disable iff (reset)
      (isTrig || isSwi) ##1 (isTrig || isSwi) |-> !pinDriven)
      else $error("Pin driven in trigger or software mode.");
   a_clear_latch_low: assert property (@(posedge mclk)
      disable iff (reset)
      (controlWrite && controlWriteData == MODE_OFF) |=> !matchOutputPin)
      else $error("Control clear left latch high.");
   a_go_with_trig: assert property (@(posedge mclk)
      disable iff (reset)
      conversionGo |-> specialEventTrigger ##1 !conversionGo)
      else $error("Conversion start without trigger.");
   a_toggle_match: assert property (@(posedge mclk)
      disable iff (reset)
      (matchEvt && mode_reg == MODE_CMP_TOGGLE && !controlWrite)
      |=> (outLatch_reg != $past(outLatch_reg)))
      else $error("Toggle mode did not toggle.");
   a_flag_sticky: assert property (@(posedge mclk)
      disable iff (reset)
      (matchFlag_reg && !matchFlagClear) |=> matchFlag_reg)
      else $error("Match flag dropped without clear.");
   a_set_drives_high: assert property (@(posedge mclk)
      disable iff (reset)
      (matchEvt && mode_reg == MODE_CMP_SET && !controlWrite) |=> outLatch_reg)
      else $error("Set mode left the latch low.");
   a_clear_drives_low: assert property (@(posedge mclk)
      disable iff (reset)
      (matchEvt && mode_reg == MODE_CMP_CLR && !controlWrite) |=> !outLatch_reg)
      else $error("Clear mode left the latch high.");
   a_swi_latch_held: assert property (@(posedge mclk)
      disable iff (reset)
      (matchEvt && isSwi && !controlWrite) |=> $stable(outLatch_reg))
      else $error("Software mode moved the latch.");
   a_trig_on_match: assert property (@(posedge mclk)
      disable iff (reset)
      (matchEvt && isTrig) |=> specialEventTrigger)
      else $error("Match in trigger mode gave no trigger.");
   a_lost_match_counts: assert property (@(posedge mclk)
      disable iff (reset)
      (timerTick && isTrig && !equal && !timerWr)
      |=> (timer_reg == $past(timer_reg) + 16'h0001))
      else $error("Timer reset although the match was gone.");
   a_capture_flag: assert property (@(posedge mclk)
      disable iff (reset)
      capEvt |=> matchFlag_reg)
      else $error("Capture did not raise the flag.");
   a_pin_owned: assert property (@(posedge mclk)
      disable iff (reset)
      pinMode |=> pinDriven)
      else $error("Pin not driven in a pin mode.");
   a_cmp_retimed: assert property (@(posedge mclk)
      disable iff (reset)
      !timerTick |=> $stable(cmpTimed_reg))
      else $error("Comparator output moved between ticks.");
endmodule : tccu_timer_capture_compare_unit
`default_nettype wire

// ==== test/tccu_timer_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module tccu_timer_partner (
   input wire logic mclk,
   input wire logic reset,
   input wire logic step,
   input wire logic conversionGo,
   output logic timerTick,
   output logic [7:0] goCount
);
   // Ticks are launched from mclk so the timer never counts asynchronously.
   always_ff @(posedge mclk) begin
      if (reset) begin
         timerTick <= 1'b0;
         goCount <= 8'h00;
      end else begin
         timerTick <= step;
         goCount <= goCount + {7'h00, conversionGo};
      end
   end
endmodule : tccu_timer_partner
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tccu_pkg::*;
   logic mclk, reset, step, timerTick, timerHighWrite, timerLowWrite;
   logic matchHighWrite, matchLowWrite, controlWrite, captureIn;
   logic comparatorIn, adcEnable, matchFlagClear, overflowFlagClear;
   logic [7:0] timerWriteData, matchWriteData, goCount;
   logic [3:0] controlWriteData, matchModeField;
   logic [15:0] timerPair, matchValuePair;
   logic matchOutputPin, pinDriven, matchFlag, timerOverflowFlag;
   logic specialEventTrigger, conversionGo, comparatorSynced;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   int trigCount = 0;
   // Modes in test order, with expected pin, driven and flag bits.
   logic [3:0] modes [5] = '{MODE_CMP_SET, MODE_OFF, MODE_CMP_TOGGLE,
      MODE_CMP_CLR, MODE_CMP_SWI};
   logic [2:0] expTab [5] = '{3'h7, 3'h0, 3'h7, 3'h3, 3'h1};

   tccu_timer_capture_compare_unit tccu_timer_capture_compare_unit_i (
      .mclk, .reset, .timerTick, .timerHighWrite, .timerLowWrite,
      .timerWriteData, .matchHighWrite, .matchLowWrite, .matchWriteData,
      .controlWrite, .controlWriteData, .captureIn, .comparatorIn,
      .adcEnable, .matchFlagClear, .overflowFlagClear, .timerPair,
      .matchValuePair, .matchModeField, .matchOutputPin, .pinDriven,
      .matchFlag, .timerOverflowFlag, .specialEventTrigger, .conversionGo,
      .comparatorSynced);
   tccu_timer_partner tccu_timer_partner_i (
      .mclk, .reset, .step, .conversionGo, .timerTick, .goCount);

   // The clock toggles every half period of 25 ns.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Trigger pulses are counted and a hung run is cut short.
   always @(posedge mclk) begin
      cycles++;
      if (!reset && specialEventTrigger === 1'b1) trigCount++;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input string name, input logic [15:0] e,
      input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask : chk

   // Single bits are widened on purpose before the compare.
   task automatic chk1(input string name, input logic e, input logic g);
      chk(name, {15'h0000, e}, {15'h0000, g});
   endtask : chk1

   // Each capture pin level is held long enough to pass the synchroniser.
   task automatic cap_edges(input int n);
      repeat (n) begin
         captureIn = 1'b1;
         idle(3);
         captureIn = 1'b0;
         idle(3);
      end
   endtask : cap_edges

   // A strobe is high for exactly one rising edge.
   task automatic pulse(ref logic s);
      @(negedge mclk) s = 1'b1;
      @(negedge mclk) s = 1'b0;
   endtask : pulse

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask : idle

   task automatic wr_timer(input logic [15:0] v);
      timerWriteData = v[15:8];
      pulse(timerHighWrite);
      timerWriteData = v[7:0];
      pulse(timerLowWrite);
   endtask : wr_timer

   task automatic wr_match(input logic [15:0] v);
      matchWriteData = v[15:8];
      pulse(matchHighWrite);
      matchWriteData = v[7:0];
      pulse(matchLowWrite);
   endtask : wr_match

   task automatic wr_mode(input logic [3:0] m);
      controlWriteData = m;
      pulse(controlWrite);
   endtask : wr_mode

   task automatic report_and_stop();
      if (n_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // Main sequence: wrap, compare modes, trigger, capture, comparator.
   initial begin
      {step, timerHighWrite, timerLowWrite, matchHighWrite} = 4'h0;
      {matchLowWrite, controlWrite, captureIn, comparatorIn} = 4'h0;
      {adcEnable, matchFlagClear, overflowFlagClear} = 3'h0;
      {timerWriteData, matchWriteData, controlWriteData} = 20'h00000;
      reset = 1'b1;
      idle(10);
      reset = 1'b0;
      chk("timer reset", TIMER_RESET, timerPair);
      wr_timer(TIMER_MAX);
      pulse(step);
      idle(2);
      chk("wrap", 16'h0000, timerPair);
      chk1("overflow flag", 1'b1, timerOverflowFlag);
      pulse(overflowFlagClear);
      // A timer write that keeps an old match counts as a fresh match, so
      // the flag is cleared only once the new mode holds.
      for (int i = 0; i < 5; i++) begin
         wr_timer(16'h0010);
         wr_match(16'h0011);
         wr_mode(modes[i]);
         pulse(matchFlagClear);
         chk1("flag early", 1'b0, matchFlag);
         chk("mode", 16'(modes[i]), 16'(matchModeField));
         pulse(step);
         idle(3);
         chk1("pin driven", expTab[i][1], pinDriven);
         chk1("match flag", expTab[i][0], matchFlag);
         chk1("pin", expTab[i][2], matchOutputPin);
      end
      adcEnable = 1'b1;
      wr_timer(16'h0020);
      wr_match(16'h0021);
      wr_mode(MODE_CMP_SET_TRIG);
      pulse(step);
      idle(3);
      chk("trigger count", 16'h0001, 16'(trigCount));
      chk("go count", 16'h0001, {8'h00, goCount});
      chk("timer held", 16'h0021, timerPair);
      chk1("pin free", 1'b0, pinDriven);
      pulse(step);
      idle(2);
      chk("period reset", 16'h0000, timerPair);
      chk1("no overflow", 1'b0, timerOverflowFlag);
      wr_timer(16'h0020);
      pulse(step);
      idle(3);
      // The next tick lands together with a write to both timer bytes.
      step = 1'b1;
      @(negedge mclk);
      step = 1'b0;
      timerWriteData = 8'h55;
      {timerHighWrite, timerLowWrite} = 2'h3;
      @(negedge mclk);
      {timerHighWrite, timerLowWrite} = 2'h0;
      chk("write wins", 16'h5555, timerPair);
      adcEnable = 1'b0;
      wr_timer(16'h0020);
      pulse(step);
      idle(3);
      wr_match(16'h0100);
      pulse(step);
      idle(2);
      chk("no reset", 16'h0022, timerPair);
      chk("trigger count", 16'h0003, 16'(trigCount));
      chk("go count", 16'h0002, {8'h00, goCount});
      // A period of the full range must end in a reset, never in a wrap.
      wr_match(TIMER_MAX);
      wr_timer(16'hfffe);
      pulse(step);
      idle(3);
      pulse(step);
      idle(2);
      chk("full period", 16'h0000, timerPair);
      chk1("no wrap flag", 1'b0, timerOverflowFlag);
      chk("trigger count", 16'h0004, 16'(trigCount));
      wr_mode(MODE_CAP_RISE);
      pulse(matchFlagClear);
      wr_timer(16'h1234);
      captureIn = 1'b1;
      idle(6);
      chk("capture rise", 16'h1234, matchValuePair);
      chk1("capture flag", 1'b1, matchFlag);
      wr_mode(MODE_CAP_FALL);
      wr_timer(16'h4321);
      captureIn = 1'b0;
      idle(6);
      chk("capture fall", 16'h4321, matchValuePair);
      // Prescaled captures take only every fourth or sixteenth rising edge.
      wr_mode(MODE_CAP_RISE4);
      wr_timer(16'h0aaa);
      cap_edges(3);
      chk("capture by 4 early", 16'h4321, matchValuePair);
      cap_edges(1);
      chk("capture by 4", 16'h0aaa, matchValuePair);
      wr_mode(MODE_CAP_RISE16);
      wr_timer(16'h0bbb);
      cap_edges(15);
      chk("capture by 16 early", 16'h0aaa, matchValuePair);
      cap_edges(1);
      chk("capture by 16", 16'h0bbb, matchValuePair);
      comparatorIn = 1'b1;
      idle(3);
      chk1("comparator held", 1'b0, comparatorSynced);
      pulse(step);
      idle(2);
      chk1("comparator sync", 1'b1, comparatorSynced);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
